// ---- shared/apf_pkg.sv ----
/*
 * Constants, field positions and types shared by the converter control block.
 * Assumes a 32-bit APB slave port whose byte address is four times the register index.
 */
`default_nettype none
package apf_pkg;
	localparam int ADDR_W = 10; // Byte address width of the register window.
	localparam int REG_W = 8; // Width of every control register.
	localparam int PORT_W = 8; // Width of the digital input port.
	typedef logic [7:0] apf_idx_t; // Register index type.
	localparam apf_idx_t IDX_CTL0 = 8'h60; // Reserved abort control.
	localparam apf_idx_t IDX_CTL1 = 8'h61; // Reserved special control.
	localparam apf_idx_t IDX_CTL2 = 8'h62; // Power and interrupt control.
	localparam apf_idx_t IDX_CTL3 = 8'h63; // Sequence and freeze control.
	localparam apf_idx_t IDX_CTL4 = 8'h64; // First conversion setup register.
	localparam apf_idx_t IDX_CTL5 = 8'h65; // Second conversion setup register.
	localparam apf_idx_t IDX_STAT = 8'h66; // Conversion status.
	localparam apf_idx_t IDX_TEST = 8'h67; // Converter test register.
	localparam apf_idx_t IDX_PORT = 8'h6F; // Digital input port data.
	localparam logic [REG_W-1:0] CTL_RST = 8'h00; // Reset value of all control registers.
	localparam logic [REG_W-1:0] CTL3_MASK = 8'h0F; // Implemented bits of the freeze control.
	localparam logic [REG_W-1:0] PWR_MASK = 8'h80; // Power-up enable bit alone.
	localparam int CTL2_PWR = 7; // Power-up enable.
	localparam int CTL2_WAIT = 5; // Stop in wait.
	localparam int CTL2_IE = 1; // Sequence complete interrupt enable.
	localparam int CTL2_FLAG = 0; // Sequence done interrupt flag.
	localparam int CTL3_S1C = 3; // Sequence length of one.
	localparam int CTL3_FRZ = 0; // Low bit of the freeze select pair.
	localparam int CTL5_S8C = 6; // Sequence length of eight.
	localparam int CTL5_SCAN = 5; // Continuous sequences.
	localparam int TEST_RST = 7; // Soft reset bit.
	localparam int STAT_SCF = 8; // Sequence complete bit in status.
	localparam int STAT_BUSY = 12; // Sequence active bit in status.
	localparam logic [1:0] FRZ_FINISH = 2'h2; // Finish conversion, then freeze.
	localparam logic [1:0] FRZ_NOW = 2'h3; // Freeze at once.
	localparam logic [3:0] LEN_1 = 4'h1; // One conversion per sequence.
	localparam logic [3:0] LEN_4 = 4'h4; // Four conversions per sequence.
	localparam logic [3:0] LEN_8 = 4'h8; // Eight conversions per sequence.
	localparam int SAMPLE_CYC = 8; // Sample period in clocks.
	localparam int CONV_CYC = 10; // Conversion period in clocks.
	localparam logic [4:0] SAMPLE_LAST = 5'(SAMPLE_CYC - 1); // Last sample count.
	localparam logic [4:0] CONV_LAST = 5'(CONV_CYC - 1); // Last conversion count.
	typedef enum logic [1:0] {SQ_IDLE, SQ_SAMPLE, SQ_CONVERT} apf_seq_e; // Sequencer states.
	// Tells whether a byte address selects the register with the given index.
	function automatic logic apf_hit(input logic [ADDR_W-1:0] a, input apf_idx_t i);
		return a == {i, 2'b00};
	endfunction : apf_hit
endpackage : apf_pkg
`default_nettype wire

// ---- shared/apf_seq_if.sv ----
/*
 * Signals between the register logic and the conversion sequencer.
 * Assumes both ends run on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
interface apf_seq_if;
	logic start; // Begin a new sequence.
	logic abort; // End any sequence at once.
	logic hold; // Keep all timing where it is.
	logic scan; // Run sequences continuously.
	logic [3:0] len; // Conversions per sequence.
	logic conv_done; // One conversion finished.
	logic seq_done; // Whole sequence finished.
	logic busy; // Sequence active.
	logic sample_start; // First clock of a sample period.
	logic [2:0] done_idx; // Slot of the finished conversion.
	modport seq (input start, abort, hold, scan, len, output conv_done, seq_done, busy, sample_start, done_idx);
	modport ctl (output start, abort, hold, scan, len, input conv_done, seq_done, busy, sample_start, done_idx);
endinterface : apf_seq_if
`default_nettype wire

// ---- hdl/apf_sync.sv ----
/*
 * Two-stage synchroniser for the digital input port pins.
 * Assumes the pins are asynchronous to the clock.
 */
`timescale 1ns/1ps
`default_nettype none
module apf_sync #(
	parameter int W = 8
) (
	input wire logic clk,
	input wire logic rst_n,
	input wire logic [W-1:0] din,
	output logic [W-1:0] dout
);
	// Both stages; only the second stage is read outside.
	typedef struct packed {
		logic [W-1:0] s1;
		logic [W-1:0] s2;
	} apf_sync_s;
	apf_sync_s q, d; // Current and next stages.
	// Shifts the pins through the two stages.
	always_comb begin
		d.s1 = din;
		d.s2 = q.s1;
	end
	// Registers the stages.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign dout = q.s2;
endmodule : apf_sync
`default_nettype wire

// ---- hdl/apf_seq.sv ----
/*
 * Conversion sequencer: sample and conversion timing for one sequence.
 * Assumes start, abort and hold come from logic on the same clock.
 */
`timescale 1ns/1ps
`default_nettype none
module apf_seq
	import apf_pkg::*;
(
	input wire logic clk,
	input wire logic rst_n,
	apf_seq_if.seq sq
);
	// All timing state of the sequencer.
	typedef struct packed {
		apf_seq_e st;
		logic [4:0] cnt;
		logic [2:0] idx;
		logic [2:0] didx;
		logic [3:0] len;
		logic scan;
		logic cdone;
		logic sdone;
	} apf_seq_s;
	apf_seq_s q, d; // Current and next state.
	// Steps the timing unless held; a start beats an abort.
	always_comb begin
		d = q;
		d.cdone = 1'b0;
		d.sdone = 1'b0;
		if (sq.start) begin
			d.st = SQ_SAMPLE;
			d.cnt = '0;
			d.idx = '0;
			d.len = sq.len;
			d.scan = sq.scan;
		end else if (sq.abort) begin
			d.st = SQ_IDLE;
			d.cnt = '0;
			d.idx = '0;
		end else if (!sq.hold) begin
			unique case (q.st)
				SQ_IDLE: begin
					d.cnt = '0;
				end
				SQ_SAMPLE: begin
					if (q.cnt == SAMPLE_LAST) begin
						d.st = SQ_CONVERT;
						d.cnt = '0;
					end else begin
						d.cnt = q.cnt + 5'h01;
					end
				end
				SQ_CONVERT: begin
					if (q.cnt == CONV_LAST) begin
						d.cnt = '0;
						d.cdone = 1'b1;
						d.didx = q.idx;
						if ({1'b0, q.idx} == q.len - 4'h1) begin
							d.sdone = 1'b1;
							d.idx = '0;
							d.st = q.scan ? SQ_SAMPLE : SQ_IDLE;
						end else begin
							d.idx = q.idx + 3'h1;
							d.st = SQ_SAMPLE;
						end
					end else begin
						d.cnt = q.cnt + 5'h01;
					end
				end
				default: begin
					d.st = SQ_IDLE;
				end
			endcase
		end
	end
	// Registers the sequencer state.
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= '0;
		end else begin
			q <= d;
		end
	end
	assign sq.conv_done = q.cdone;
	assign sq.seq_done = q.sdone;
	assign sq.done_idx = q.didx;
	assign sq.busy = q.st != SQ_IDLE;
	assign sq.sample_start = (q.st == SQ_SAMPLE) && (q.cnt == '0);
endmodule : apf_seq
`default_nettype wire

// ---- hdl/apf_ctrl.sv ----
/*
 * Converter power, freeze, reset and restart control with its APB register file.
 * Assumes stop, wait and freeze come from logic on ref_clk and the port pins are asynchronous.
 */
// Functional notes
// - Stop powers the converter down fully.
// - Wait powers down only with stop-in-wait set.
// - No register access while down for wait.
// - Freeze select: ignore, finish conversion, immediate.
// - Frozen logic holds state, resumes after release.
// - Registers stay accessible while frozen.
// - System reset or test soft-reset bit resets.
// - Soft reset keeps the power-up enable.
// - Reset ends sequence, clears flags and registers.
// - Leaving wait resumes without any reset.
// - Freeze never resets the converter.
// - Power-up enable never reinitialises registers.
// - Setup register write restarts and clears flags.
// - Eight-bit input-only digital port readable.
// - Port reads never disturb a conversion.
// - Each instance owns one register block.
// - Reserved register zero write aborts sequence.
// - Reserved register one ignores writes, special reads.
// - Writes to registers two, three never restart.
// - Sequence done flag is read-only.
// - Power-up enable low powers the converter down.
// - Stop or power-up enable low aborts the sequence; wait only holds it.
// - Power-up enable resets to zero.
`timescale 1ns/1ps
`default_nettype none
module apf_ctrl
	import apf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [ADDR_W-1:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	input wire logic mcu_stop,
	input wire logic mcu_wait,
	input wire logic debug_freeze_request,
	input wire logic special_mode,
	input wire logic [PORT_W-1:0] digital_input_port,
	output logic analog_power_en,
	output logic digital_clk_en,
	output logic conv_busy
);
	// Whole register and bus state of the block.
	typedef struct packed {
		logic [REG_W-1:0] ctl0;
		logic [REG_W-1:0] ctl2;
		logic [REG_W-1:0] ctl3;
		logic [REG_W-1:0] ctl4;
		logic [REG_W-1:0] ctl5;
		logic [REG_W-1:0] test;
		logic [REG_W-1:0] ccf;
		logic scf;
		logic [31:0] rdata;
		logic ready;
		logic err;
		logic apwr;
		logic dclk;
		logic busy;
	} apf_top_s;
	localparam apf_top_s TOP_RST = '0; // Every field resets to zero.
	apf_top_s q, d; // Current and next state.
	logic [PORT_W-1:0] port_sync; // Synchronised port pins.
	logic wait_dn; // Powered down for wait.
	logic powered; // Digital and analog power allowed.
	logic acc1; // First access cycle of a transfer.
	logic acc2; // Completing access cycle of a transfer.
	logic wr2; // Write that takes effect at this edge.
	logic wr_ctl0; // Write to reserved register zero.
	logic wr_conv; // Write to a setup register.
	logic hit5; // Address selects setup register five.
	logic [REG_W-1:0] c5n; // Register five value for a new sequence.
	logic [1:0] frz_mode; // Selected freeze response.
	logic hold_frz; // Freeze holds the sequencer now.
	logic [32:0] rd_res; // Read validity and data.

	apf_seq_if sq(); // Link to the sequencer.

	// Timing engine of the conversion sequence.
	apf_seq u_seq (
		.clk(ref_clk),
		.rst_n(rst_n),
		.sq(sq)
	);

	// Port pins come from outside the clock domain.
	apf_sync #(
		.W(PORT_W)
	) u_sync (
		.clk(ref_clk),
		.rst_n(rst_n),
		.din(digital_input_port),
		.dout(port_sync)
	);

	// Builds the read word of a register and tells whether the address is mapped.
	function automatic logic [32:0] rd_word(input logic [ADDR_W-1:0] a, input apf_top_s s,
		input logic [PORT_W-1:0] pins, input logic spec, input logic busy, input logic [2:0] di);
		logic [31:0] w;
		w = '0;
		if (apf_hit(a, IDX_CTL0)) begin
			w[REG_W-1:0] = s.ctl0;
		end else if (apf_hit(a, IDX_CTL1)) begin
			return {spec, w};
		end else if (apf_hit(a, IDX_CTL2)) begin
			w[REG_W-1:0] = s.ctl2;
		end else if (apf_hit(a, IDX_CTL3)) begin
			w[REG_W-1:0] = s.ctl3;
		end else if (apf_hit(a, IDX_CTL4)) begin
			w[REG_W-1:0] = s.ctl4;
		end else if (apf_hit(a, IDX_CTL5)) begin
			w[REG_W-1:0] = s.ctl5;
		end else if (apf_hit(a, IDX_STAT)) begin
			w[REG_W-1:0] = s.ccf;
			w[STAT_SCF] = s.scf;
			w[STAT_BUSY-1:STAT_SCF+1] = di;
			w[STAT_BUSY] = busy;
		end else if (apf_hit(a, IDX_TEST)) begin
			w[REG_W-1:0] = s.test;
		end else if (apf_hit(a, IDX_PORT)) begin
			w[PORT_W-1:0] = pins;
		end else begin
			return {1'b0, w};
		end
		return {1'b1, w};
	endfunction : rd_word

	// Power state: stop always, wait only with stop-in-wait, and the enable bit.
	assign wait_dn = mcu_wait & q.ctl2[CTL2_WAIT];
	assign powered = q.ctl2[CTL2_PWR] & ~mcu_stop & ~wait_dn;

	// Bus phases: the answer comes one cycle into the access phase.
	assign acc1 = psel & penable & ~q.ready;
	assign acc2 = psel & penable & q.ready;
	assign wr2 = acc2 & pwrite & ~q.err & ~wait_dn;
	assign wr_ctl0 = wr2 & apf_hit(paddr, IDX_CTL0);
	assign hit5 = apf_hit(paddr, IDX_CTL5);
	assign wr_conv = wr2 & (apf_hit(paddr, IDX_CTL4) | hit5);
	assign c5n = (wr2 & hit5) ? pwdata[REG_W-1:0] : q.ctl5;
	assign rd_res = rd_word(paddr, q, port_sync, special_mode, sq.busy, sq.done_idx);

	// Freeze response from the two select bits.
	assign frz_mode = q.ctl3[CTL3_FRZ+1:CTL3_FRZ];
	assign hold_frz = debug_freeze_request & ((frz_mode == FRZ_NOW) |
		((frz_mode == FRZ_FINISH) & (sq.sample_start | ~sq.busy)));

	// Sequencer control; writes to registers two and three never start it.
	// A restart during stop must not outrun the abort, so only a powered converter starts.
	assign sq.start = wr_conv & powered;
	assign sq.abort = wr_ctl0 | wr_conv | ~q.ctl2[CTL2_PWR] | mcu_stop | q.test[TEST_RST];
	assign sq.hold = wait_dn | hold_frz;
	assign sq.scan = c5n[CTL5_SCAN];
	assign sq.len = c5n[CTL5_S8C] ? LEN_8 : (q.ctl3[CTL3_S1C] ? LEN_1 : LEN_4);

	// Next state: bus answer, register writes, flags, then soft reset.
	always_comb begin
		d = q;
		d.ready = acc1;
		if (acc1) begin
			// Unmapped addresses and accesses while down for wait answer with an error.
			d.err = ~rd_res[32] | wait_dn;
			d.rdata = (rd_res[32] & ~wait_dn) ? rd_res[31:0] : '0;
		end
		if (wr2) begin
			// Register two keeps its flag, register three keeps only its low four bits; registers zero, four, five and test store the byte.
			if (apf_hit(paddr, IDX_CTL0)) begin
				d.ctl0 = pwdata[REG_W-1:0];
			end else if (apf_hit(paddr, IDX_CTL2)) begin
				d.ctl2 = {pwdata[REG_W-1:CTL2_FLAG+1], q.ctl2[CTL2_FLAG]};
			end else if (apf_hit(paddr, IDX_CTL3)) begin
				d.ctl3 = pwdata[REG_W-1:0] & CTL3_MASK;
			end else if (apf_hit(paddr, IDX_CTL4)) begin
				d.ctl4 = pwdata[REG_W-1:0];
			end else if (hit5) begin
				d.ctl5 = pwdata[REG_W-1:0];
			end else if (apf_hit(paddr, IDX_TEST)) begin
				d.test = pwdata[REG_W-1:0];
			end
		end
		// A restart clears the flags; a flag set in the same cycle still wins.
		if (wr_conv) begin
			d.ccf = '0;
			d.scf = 1'b0;
			d.ctl2[CTL2_FLAG] = 1'b0;
		end
		if (sq.conv_done) begin
			d.ccf[sq.done_idx] = 1'b1;
		end
		if (sq.seq_done) begin
			d.scf = 1'b1;
			if (q.ctl2[CTL2_IE]) begin
				d.ctl2[CTL2_FLAG] = 1'b1;
			end
		end
		// Soft reset initialises everything except the power-up enable, and clears itself.
		if (q.test[TEST_RST]) begin
			d.ctl0 = CTL_RST;
			d.ctl2 = CTL_RST | (q.ctl2 & PWR_MASK);
			d.ctl3 = CTL_RST;
			d.ctl4 = CTL_RST;
			d.ctl5 = CTL_RST;
			d.test = CTL_RST;
			d.ccf = '0;
			d.scf = 1'b0;
		end
		// Power outputs; freezing stops the digital clock but keeps the analog bias.
		d.apwr = powered;
		d.dclk = powered & ~hold_frz;
		d.busy = sq.busy;
	end

	// Registers the whole state; system reset clears the power-up enable too.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			q <= TOP_RST;
		end else begin
			q <= d;
		end
	end

	assign prdata = q.rdata;
	assign pready = q.ready;
	assign pslverr = q.err;
	assign analog_power_en = q.apwr;
	assign digital_clk_en = q.dclk;
	assign conv_busy = q.busy;

	// A two-cycle access phase of any transfer.
	sequence apb_xfer_s;
		(psel && penable && !pready) ##1 (psel && penable && pready);
	endsequence
	// A freeze- or wait-held cycle of a running sequence.
	sequence held_s;
		sq.hold && sq.busy && !sq.start && !sq.abort;
	endsequence

	// Stop removes power at the next edge.
	stop_power_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mcu_stop |=> !analog_power_en) else $error("stop did not power down");
	// Wait without stop-in-wait leaves the converter running.
	wait_ignore_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mcu_wait && !q.ctl2[CTL2_WAIT] && q.ctl2[CTL2_PWR] && !mcu_stop) |=> analog_power_en)
		else $error("wait powered down without stop-in-wait");
	// Accesses while down for wait answer with an error.
	wait_noacc_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(acc1 && wait_dn) |=> (pready && pslverr)) else $error("access allowed during wait");
	// Immediate freeze stops the sequence and the digital clock at the next edge.
	frz_now_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(debug_freeze_request && frz_mode == FRZ_NOW && sq.busy && !sq.start && !sq.abort) |=>
		(sq.busy && !sq.conv_done && !digital_clk_en)) else $error("immediate freeze missed");
	// A held sequence keeps its position.
	frz_hold_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		held_s |=> ($stable(sq.done_idx) && sq.busy && !sq.conv_done)) else $error("frozen sequence moved");
	// Mapped reads while frozen are answered without error.
	frz_access_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(debug_freeze_request && !wait_dn && acc1 && rd_res[32]) |=> !pslverr)
		else $error("register access refused while frozen");
	// Soft reset keeps the power-up enable and clears the test bit.
	srst_keep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		q.test[TEST_RST] |=> (q.ctl2[CTL2_PWR] == $past(q.ctl2[CTL2_PWR]) && !q.test[TEST_RST] && q.ccf == '0))
		else $error("soft reset changed power-up enable");
	// A setup write restarts and clears the flags.
	restart_clr_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(wr_conv && powered && !sq.conv_done && !sq.seq_done) |=> (q.ccf == '0 && !q.scf && sq.busy))
		else $error("restart did not clear flags");
	// Power-up enable low ends any sequence within one edge.
	pwr_abort_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!q.ctl2[CTL2_PWR] && !sq.start) |=> !sq.busy) else $error("sequence kept running while off");
	// A read of the port returns the synchronised pins.
	port_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		((!pwrite && apf_hit(paddr, IDX_PORT) && !wait_dn) ##0 apb_xfer_s) |->
		(prdata[PORT_W-1:0] == $past(port_sync))) else $error("port read wrong");
endmodule : apf_ctrl
`default_nettype wire

// ---- verif/apf_cpu_bfm.sv ----
/*
 * Processor model: turns each bench request into one APB transfer.
 * Assumes an APB slave on ref_clk and a request held until ack is seen.
 */
`timescale 1ns/1ps
`default_nettype none
module apf_cpu_bfm
	import apf_pkg::*;
(
	input wire logic ref_clk,
	input wire logic rst_n,
	input wire logic req,
	input wire logic req_wr,
	input wire logic [ADDR_W-1:0] req_addr,
	input wire logic [31:0] req_wdata,
	output logic ack,
	output logic [31:0] ack_rdata,
	output logic ack_err,
	output logic psel,
	output logic penable,
	output logic pwrite,
	output logic [ADDR_W-1:0] paddr,
	output logic [31:0] pwdata,
	input wire logic [31:0] prdata,
	input wire logic pready,
	input wire logic pslverr
);
	// Setup cycle, then access held until pready is seen at a rising edge.
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			psel <= 1'b0;
			penable <= 1'b0;
			pwrite <= 1'b0;
			paddr <= '0;
			pwdata <= '0;
			ack <= 1'b0;
			ack_rdata <= '0;
			ack_err <= 1'b0;
		end else begin
			ack <= psel && penable && pready;
			if (psel && penable && pready) begin
				// The answer is taken here; the released address and write data show inverted values.
				psel <= 1'b0;
				penable <= 1'b0;
				paddr <= ~paddr;
				pwdata <= ~pwdata;
				ack_rdata <= prdata;
				ack_err <= pslverr;
			end else if (psel) begin
				// The access phase follows the setup cycle.
				penable <= 1'b1;
			end else if (req && !ack) begin
				// A new setup cycle starts only once the last answer is consumed.
				psel <= 1'b1;
				pwrite <= req_wr;
				paddr <= req_addr;
				pwdata <= req_wdata;
			end
		end
	end
endmodule : apf_cpu_bfm
`default_nettype wire

// ---- verif/tb_top.sv ----
/*
 * Self-checking bench for the converter control block.
 * Assumes the block answers APB with a bounded wait and a 100 MHz clock.
 */
`timescale 1ns/1ps
`default_nettype none
module tb_top
	import apf_pkg::*;
;
	logic ref_clk = 1'b0, rst_n = 1'b0, req = 1'b0, req_wr = 1'b0; // Clock, reset and request.
	logic [ADDR_W-1:0] req_addr = '0; // Requested byte address.
	logic [31:0] req_wdata = '0; // Requested write data.
	logic mcu_stop = 1'b0, mcu_wait = 1'b0, frz = 1'b0, special_mode = 1'b0; // Processor states.
	logic [7:0] port = 8'h00; // Digital input pins.
	logic ack, ack_err, psel, penable, pwrite, pready, pslverr, pwr_en, clk_en, busy; // Observed bits.
	logic [31:0] ack_rdata, pwdata, prdata; // Bus data.
	logic [ADDR_W-1:0] paddr; // Bus address.
	int err_count = 0, tests_run = 0; // Mismatch and comparison counts.

	// The clock toggles every half period.
	always #5 ref_clk = ~ref_clk;

	apf_cpu_bfm apf_cpu_bfm_i (.ref_clk(ref_clk), .rst_n(rst_n), .req(req), .req_wr(req_wr),
		.req_addr(req_addr), .req_wdata(req_wdata), .ack(ack), .ack_rdata(ack_rdata), .ack_err(ack_err),
		.psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata),
		.prdata(prdata), .pready(pready), .pslverr(pslverr));
	apf_ctrl apf_ctrl_i (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
		.pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .mcu_stop(mcu_stop), .mcu_wait(mcu_wait), .debug_freeze_request(frz),
		.special_mode(special_mode), .digital_input_port(port), .analog_power_en(pwr_en),
		.digital_clk_en(clk_en), .conv_busy(busy));

	// Prints the counts and the verdict, then ends the run.
	task automatic give_verdict();
		$display("comparisons %0d, mismatches %0d", tests_run, err_count);
		if (err_count == 0 && tests_run > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : give_verdict

	// Compares one value and reports a mismatch at once.
	task automatic chk(input string what, input logic [31:0] exp, input logic [31:0] got);
		tests_run++;
		if (got !== exp) begin
			err_count++;
			$display("unexpected %s: expected %h, seen %h", what, exp, got);
		end
	endtask : chk

	// Waits the given number of clock edges.
	task automatic cyc(input int n);
		repeat (n) @(posedge ref_clk);
	endtask : cyc

	// One register transfer through the processor model, bounded in time.
	task automatic apb(input logic w, input apf_idx_t idx, input logic [7:0] v, output logic [31:0] d,
		output logic e);
		int n;
		@(posedge ref_clk);
		req <= 1'b1;
		req_wr <= w;
		req_addr <= {idx, 2'b00};
		req_wdata <= {24'h0, v};
		n = 0;
		do begin
			@(posedge ref_clk);
			n++;
		end while (ack !== 1'b1 && n < 50);
		if (n >= 50) chk("bus answer", 32'h1, 32'h0);
		req <= 1'b0;
		d = ack_rdata;
		e = ack_err;
	endtask : apb

	// Writes one register.
	task automatic wr(input apf_idx_t idx, input logic [7:0] v);
		logic [31:0] d;
		logic e;
		apb(1'b1, idx, v, d, e);
	endtask : wr

	// Reads one register and compares it.
	task automatic rdc(input apf_idx_t idx, input logic [7:0] exp, input string what);
		logic [31:0] d;
		logic e;
		apb(1'b0, idx, 8'h00, d, e);
		chk(what, {24'h0, exp}, d);
	endtask : rdc

	// Waits a bounded time for the busy flag to reach a level, then compares it.
	task automatic wbusy(input logic exp);
		int n;
		n = 0;
		while (busy !== exp && n < 60) begin
			@(posedge ref_clk);
			n++;
		end
		chk("conv_busy", 32'(exp), 32'(busy));
	endtask : wbusy

	// Reset values, reserved register access and an unmapped address.
	task automatic t_reset();
		logic [31:0] d;
		logic e;
		rdc(IDX_CTL2, 8'h00, "power control after reset");
		chk("analog_power_en", 32'h0, 32'(pwr_en));
		apb(1'b0, IDX_CTL1, 8'h00, d, e);
		chk("reserved read error", 32'h1, 32'(e));
		special_mode <= 1'b1;
		apb(1'b0, IDX_CTL1, 8'h00, d, e);
		chk("special reserved read error", 32'h0, 32'(e));
		special_mode <= 1'b0;
		apb(1'b0, 8'h70, 8'h00, d, e);
		chk("unmapped read error", 32'h1, 32'(e));
		$display("test reset done");
	endtask : t_reset

	// Power up, a short sequence, flag behaviour, restart, port read and abort.
	task automatic t_seq();
		logic [31:0] d;
		logic e;
		port <= 8'hA5;
		wr(IDX_CTL2, 8'h82);
		cyc(2);
		chk("analog_power_en", 32'h1, 32'(pwr_en));
		wr(IDX_CTL3, 8'h08);
		cyc(2);
		chk("conv_busy after control three", 32'h0, 32'(busy));
		wr(IDX_CTL4, 8'h00);
		wbusy(1'b1);
		rdc(IDX_PORT, 8'hA5, "digital_input_port");
		wbusy(1'b0);
		apb(1'b0, IDX_STAT, 8'h00, d, e);
		chk("sequence done", 32'h1, 32'(d[STAT_SCF]));
		rdc(IDX_CTL2, 8'h83, "flag set");
		wr(IDX_CTL2, 8'h82);
		rdc(IDX_CTL2, 8'h83, "flag after write");
		wr(IDX_CTL5, 8'h00);
		rdc(IDX_CTL2, 8'h82, "flag after restart");
		chk("conv_busy after restart", 32'h1, 32'(busy));
		wr(IDX_CTL0, 8'h00);
		cyc(3);
		chk("conv_busy after abort", 32'h0, 32'(busy));
		wr(IDX_CTL5, 8'h40);
		cyc(150);
		apb(1'b0, IDX_STAT, 8'h00, d, e);
		chk("status after eight conversions", 32'h00000FFF, d);
		wr(IDX_CTL5, 8'h00);
		$display("test sequence done");
	endtask : t_seq

	// Freeze raised in mid-sample for one select value, then released.
	task automatic t_freeze(input logic [1:0] mode);
		logic [31:0] d;
		logic e;
		wr(IDX_CTL3, {6'h02, mode});
		wr(IDX_CTL4, 8'h00);
		cyc(5);
		frz <= 1'b1;
		cyc(40);
		apb(1'b0, IDX_STAT, 8'h00, d, e);
		chk("status error while frozen", 32'h0, 32'(e));
		chk("done while frozen", 32'(mode != FRZ_NOW), 32'(d[STAT_SCF]));
		chk("digital_clk_en while frozen", 32'(mode != FRZ_NOW && mode != FRZ_FINISH), 32'(clk_en));
		if (mode == FRZ_NOW) begin
			chk("conv_busy while frozen", 32'h1, 32'(busy));
		end
		frz <= 1'b0;
		wbusy(1'b0);
		$display("test freeze mode %0d done", mode);
	endtask : t_freeze

	// Wait with and without stop-in-wait, resuming where it was.
	task automatic t_wait();
		logic [31:0] d;
		logic e;
		wr(IDX_CTL2, 8'h82);
		mcu_wait <= 1'b1;
		cyc(3);
		chk("analog_power_en in ignored wait", 32'h1, 32'(pwr_en));
		apb(1'b0, IDX_CTL2, 8'h00, d, e);
		chk("read error in ignored wait", 32'h0, 32'(e));
		mcu_wait <= 1'b0;
		wr(IDX_CTL2, 8'hA2);
		wr(IDX_CTL4, 8'h00);
		cyc(4);
		mcu_wait <= 1'b1;
		cyc(3);
		chk("analog_power_en in wait", 32'h0, 32'(pwr_en));
		apb(1'b0, IDX_CTL2, 8'h00, d, e);
		chk("read error in wait", 32'h1, 32'(e));
		cyc(30);
		mcu_wait <= 1'b0;
		cyc(2);
		chk("conv_busy after wait", 32'h1, 32'(busy));
		wbusy(1'b0);
		rdc(IDX_CTL2, 8'hA3, "power control after wait");
		$display("test wait done");
	endtask : t_wait

	// Stop and power bit clear both abort; registers survive power-down.
	task automatic t_stop();
		wr(IDX_CTL5, 8'h20);
		cyc(40);
		chk("conv_busy in scan", 32'h1, 32'(busy));
		mcu_stop <= 1'b1;
		cyc(3);
		chk("analog_power_en in stop", 32'h0, 32'(pwr_en));
		chk("digital_clk_en in stop", 32'h0, 32'(clk_en));
		chk("conv_busy in stop", 32'h0, 32'(busy));
		mcu_stop <= 1'b0;
		cyc(3);
		chk("analog_power_en after stop", 32'h1, 32'(pwr_en));
		rdc(IDX_CTL2, 8'hA3, "power control after stop");
		wr(IDX_CTL4, 8'h00);
		cyc(2);
		wr(IDX_CTL2, 8'h22);
		cyc(3);
		chk("analog_power_en bit clear", 32'h0, 32'(pwr_en));
		chk("conv_busy bit clear", 32'h0, 32'(busy));
		wr(IDX_CTL2, 8'hA2);
		rdc(IDX_CTL3, 8'h0B, "freeze control kept");
		$display("test stop done");
	endtask : t_stop

	// Soft reset keeps power, clears the rest; then a system reset.
	task automatic t_resets();
		logic [31:0] d;
		logic e;
		wr(IDX_CTL4, 8'h00);
		cyc(2);
		wr(IDX_TEST, 8'h80);
		cyc(2);
		chk("conv_busy after soft reset", 32'h0, 32'(busy));
		chk("analog_power_en after soft reset", 32'h1, 32'(pwr_en));
		rdc(IDX_CTL2, 8'h80, "power control after soft reset");
		rdc(IDX_CTL3, 8'h00, "freeze control after soft reset");
		rdc(IDX_TEST, 8'h00, "test register after soft reset");
		wr(IDX_CTL4, 8'h00);
		cyc(80);
		apb(1'b0, IDX_STAT, 8'h00, d, e);
		chk("status after four conversions", 32'h0000070F, d);
		wr(IDX_CTL4, 8'h00);
		@(posedge ref_clk);
		rst_n <= 1'b0;
		cyc(5);
		rst_n <= 1'b1;
		cyc(1);
		chk("analog_power_en after reset", 32'h0, 32'(pwr_en));
		chk("conv_busy after reset", 32'h0, 32'(busy));
		rdc(IDX_CTL2, 8'h00, "power control after reset");
		$display("test resets done");
	endtask : t_resets

	// Main sequence: reset for five cycles, then every scenario.
	initial begin
		cyc(5);
		rst_n <= 1'b1;
		t_reset();
		t_seq();
		t_freeze(2'h0);
		t_freeze(FRZ_FINISH);
		t_freeze(FRZ_NOW);
		t_wait();
		t_stop();
		t_resets();
		give_verdict();
	end

	// Cuts a hang short well beyond the expected run length.
	initial begin
		cyc(5000);
		err_count++;
		give_verdict();
	end
endmodule : tb_top
`default_nettype wire
